/* File: ees_pkg.sv */
// Shared constants and types for the two-wire serial memory link
package ees_pkg;
  localparam int unsigned MEM_BYTES = 1024;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [3:0] TYPE_CODE = 4'hA;
  localparam int unsigned TYPE_MSB = 7;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned SEL_BIT = 3;
  localparam int unsigned PAGE_MSB = 2;
  localparam int unsigned PAGE_LSB = 1;
  localparam int unsigned RW_BIT = 0;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_RESYNC = 4'h3;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int unsigned CLOCK_PERIOD_NS = 20;
  localparam int unsigned PROG_TIME_US = 3000;
  localparam int unsigned PROG_MAX_US = 4000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * 1000 / CLOCK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W = 18;
  localparam int unsigned SCL_MIN_PERIOD_NS = 1000;
  localparam int unsigned QUARTER_CYCLES = (SCL_MIN_PERIOD_NS + 4 * CLOCK_PERIOD_NS - 1) / (4 * CLOCK_PERIOD_NS);
  localparam logic [3:0] QUARTER_LAST = 4'(QUARTER_CYCLES - 1);
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [3:0] RECOVER_LAST = 4'h8;

  typedef enum logic [2:0] {L_IDLE, L_DEV, L_WADDR, L_WDATA, L_READ} ees_link_st_t;

  typedef struct packed {
    ees_link_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic [7:0] tx;
    logic [9:0] addr;
    logic [5:0] wpage;
    logic [15:0][7:0] pbuf;
    logic [15:0] mask;
    logic armed;
    logic seen;
    logic stg_s1;
    logic stg_s2;
    logic bsy_s1;
    logic bsy_s2;
    logic sel_s1;
    logic sel_s2;
  } ees_link_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic wp_s1;
    logic wp_s2;
    logic arm_s1;
    logic arm_s2;
    logic stg;
    logic frame;
    logic busy;
    logic stby;
    logic [PROG_CNT_W-1:0] timer;
  } ees_core_t;

  typedef enum logic [3:0] {H_REC, H_RSTART, H_RSTOP, H_IDLE, H_START, H_TX, H_TACK, H_RX, H_RACK,
                            H_STOP} ees_host_st_t;
  typedef enum logic [2:0] {P_DEVW, P_ADDR, P_DATA, P_DEVR, P_POLL, P_WDONE, P_END, P_ERR} ees_phase_t;
  typedef enum logic [1:0] {K_BIT, K_START, K_STOP, K_NONE} ees_slot_t;

  typedef struct packed {
    ees_host_st_t st;
    ees_phase_t ph;
    logic [1:0] q;
    logic [3:0] qc;
    logic [3:0] bitn;
    logic [3:0] rec;
    logic [7:0] sh;
    logic [7:0] rxb;
    logic [3:0] cnt;
    logic [9:0] addr;
    logic rd;
    logic smp;
    logic sda_s1;
    logic sda_s2;
    logic scl;
    logic oe;
    logic [7:0] rdata;
    logic rvalid;
    logic wtake;
    logic done;
    logic nack;
  } ees_host_t;
endpackage : ees_pkg

/* File: ees_link_if.sv */
// Open-drain two-wire link between the memory device and its bus controller
`timescale 1ns/10ps
interface ees_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;

  // Pulled high unless one end drives low
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
endinterface : ees_link_if

/* File: ees_device.sv */
// Two-wire serial memory device: bit engine on the serial clock, array and program timer on clock
`timescale 1ns/10ps
module ees_device #(
  parameter int unsigned PROG_CYCLES = ees_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic write_protect,
  input wire logic hardwired_select_input,
  output logic standby,
  output logic program_busy,
  ees_link_if.device lnk
);

  ees_pkg::ees_link_t lk_q;
  ees_pkg::ees_link_t lk_d;
  ees_pkg::ees_core_t co_q;
  ees_pkg::ees_core_t co_d;
  logic [7:0] mem_q [ees_pkg::MEM_BYTES];
  logic [7:0] rx_byte;
  logic [9:0] rd_addr;
  logic sda_oe_q;
  logic start_ev;
  logic stop_ev;
  logic commit;

  function automatic logic dev_match(input logic [7:0] b, input logic sel);
    dev_match = (b[ees_pkg::TYPE_MSB:ees_pkg::TYPE_LSB] == ees_pkg::TYPE_CODE) && (b[ees_pkg::SEL_BIT] == sel);
  endfunction : dev_match

  // Serial clock domain
  always_comb begin
    lk_d = lk_q;
    rx_byte = {lk_q.sh[6:0], lnk.sda};
    rd_addr = lk_q.addr;
    lk_d.stg_s1 = co_q.stg;
    lk_d.stg_s2 = lk_q.stg_s1;
    lk_d.bsy_s1 = co_q.busy;
    lk_d.bsy_s2 = lk_q.bsy_s1;
    lk_d.sel_s1 = hardwired_select_input;
    lk_d.sel_s2 = lk_q.sel_s1;
    lk_d.sh = rx_byte;
    if (lk_q.stg_s2 != lk_q.seen) begin
      // Start reported by the clock domain: two bits already shifted, this edge is the third
      lk_d.seen = lk_q.stg_s2;
      lk_d.st = ees_pkg::L_DEV;
      lk_d.cnt = ees_pkg::CNT_RESYNC;
      lk_d.ack = 1'b0;
      lk_d.armed = 1'b0;
      lk_d.mask = '0;
    end else if (lk_q.cnt == ees_pkg::CNT_ACK) begin
      lk_d.cnt = '0;
      lk_d.ack = 1'b0;
      if (lk_q.st == ees_pkg::L_READ && !lk_q.ack) begin
        if (lnk.sda) begin
          lk_d.st = ees_pkg::L_IDLE;
        end else begin
          lk_d.tx = mem_q[lk_q.addr];
          lk_d.addr = lk_q.addr + 10'h1;
        end
      end
    end else begin
      lk_d.cnt = lk_q.cnt + ees_pkg::CNT_ONE;
      if (lk_q.st == ees_pkg::L_READ) begin
        lk_d.tx = {lk_q.tx[6:0], 1'b1};
      end
      if (lk_q.cnt == ees_pkg::CNT_LAST) begin
        unique case (lk_q.st)
          ees_pkg::L_DEV: begin
            if (dev_match(rx_byte, lk_q.sel_s2) && !lk_q.bsy_s2) begin
              lk_d.ack = 1'b1;
              rd_addr = {rx_byte[ees_pkg::PAGE_MSB:ees_pkg::PAGE_LSB], lk_q.addr[7:0]};
              lk_d.addr = rd_addr;
              if (rx_byte[ees_pkg::RW_BIT]) begin
                lk_d.st = ees_pkg::L_READ;
                lk_d.tx = mem_q[rd_addr];
                lk_d.addr = rd_addr + 10'h1;
              end else begin
                lk_d.st = ees_pkg::L_WADDR;
              end
            end else begin
              lk_d.st = ees_pkg::L_IDLE;
            end
          end
          ees_pkg::L_WADDR: begin
            lk_d.addr = {lk_q.addr[9:8], rx_byte};
            lk_d.wpage = {lk_q.addr[9:8], rx_byte[7:4]};
            lk_d.ack = 1'b1;
            lk_d.st = ees_pkg::L_WDATA;
          end
          ees_pkg::L_WDATA: begin
            lk_d.pbuf[lk_q.addr[3:0]] = rx_byte;
            lk_d.mask[lk_q.addr[3:0]] = 1'b1;
            lk_d.addr = {lk_q.addr[9:4], lk_q.addr[3:0] + 4'h1};
            lk_d.armed = 1'b1;
            lk_d.ack = 1'b1;
          end
          ees_pkg::L_READ, ees_pkg::L_IDLE: begin
            lk_d.ack = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge lnk.scl or negedge rst_b) begin
    if (!rst_b) begin
      lk_q <= '{st: ees_pkg::L_IDLE, default: '0};
    end else begin
      lk_q <= lk_d;
    end
  end

  // Output pin changes only on the falling serial clock edge
  always_ff @(negedge lnk.scl or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (lk_q.cnt == ees_pkg::CNT_ACK && lk_q.ack) ||
                  (lk_q.st == ees_pkg::L_READ && lk_q.cnt != ees_pkg::CNT_ACK && !lk_q.ack && !lk_q.tx[7]);
    end
  end

  assign lnk.sda_dev_o = 1'b0;
  assign lnk.sda_dev_oe = sda_oe_q;

  // Clock domain: start and stop watch, program timer
  always_comb begin
    co_d = co_q;
    co_d.scl_s1 = lnk.scl;
    co_d.scl_s2 = co_q.scl_s1;
    co_d.scl_p = co_q.scl_s2;
    co_d.sda_s1 = lnk.sda;
    co_d.sda_s2 = co_q.sda_s1;
    co_d.sda_p = co_q.sda_s2;
    co_d.wp_s1 = write_protect;
    co_d.wp_s2 = co_q.wp_s1;
    co_d.arm_s1 = lk_q.armed;
    co_d.arm_s2 = co_q.arm_s1;
    start_ev = co_q.scl_s2 && co_q.scl_p && co_q.sda_p && !co_q.sda_s2;
    stop_ev = co_q.scl_s2 && co_q.scl_p && !co_q.sda_p && co_q.sda_s2;
    commit = stop_ev && co_q.arm_s2 && !co_q.wp_s2 && !co_q.busy;
    if (start_ev) begin
      co_d.stg = !co_q.stg;
      co_d.frame = 1'b1;
    end
    if (stop_ev) begin
      co_d.frame = 1'b0;
    end
    if (co_q.busy) begin
      co_d.timer = co_q.timer - ees_pkg::PROG_CNT_W'(1);
      if (co_q.timer == ees_pkg::PROG_CNT_W'(1)) begin
        co_d.busy = 1'b0;
      end
    end
    if (commit) begin
      co_d.busy = 1'b1;
      co_d.timer = ees_pkg::PROG_CNT_W'(PROG_CYCLES);
    end
    co_d.stby = !co_d.frame && !co_d.busy;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      co_q <= '{stby: 1'b1, default: '0};
    end else begin
      co_q <= co_d;
    end
  end

  // Page buffer and mask are frozen while armed and the serial clock is parked after stop
  always_ff @(posedge clock) begin
    if (commit) begin
      for (int i = 0; i < ees_pkg::PAGE_BYTES; i++) begin
        if (lk_q.mask[i]) begin
          mem_q[{lk_q.wpage, 4'(i)}] <= lk_q.pbuf[i];
        end
      end
    end
  end

  assign standby = co_q.stby;
  assign program_busy = co_q.busy;

endmodule : ees_device

/* File: ees_host.sv */
// Two-wire bus controller: generates the serial clock and runs memory commands
`timescale 1ns/10ps
module ees_host (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic target_select,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [9:0] cmd_addr,
  input wire logic [3:0] cmd_count,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack_err,
  ees_link_if.host lnk
);

  ees_pkg::ees_host_t h_q;
  ees_pkg::ees_host_t h_d;
  logic slot_end;
  logic [1:0] lines;

  function automatic ees_pkg::ees_slot_t slot_kind(input ees_pkg::ees_host_st_t st);
    unique case (st)
      ees_pkg::H_IDLE: slot_kind = ees_pkg::K_NONE;
      ees_pkg::H_RSTART, ees_pkg::H_START: slot_kind = ees_pkg::K_START;
      ees_pkg::H_RSTOP, ees_pkg::H_STOP: slot_kind = ees_pkg::K_STOP;
      ees_pkg::H_REC, ees_pkg::H_TX, ees_pkg::H_TACK, ees_pkg::H_RX, ees_pkg::H_RACK: slot_kind = ees_pkg::K_BIT;
    endcase
  endfunction : slot_kind

  // Returns {scl, sda} for a quarter of a slot; in bit slots data moves only with the clock low, start and stop move it with the clock high
  function automatic logic [1:0] slot_lines(input ees_pkg::ees_slot_t k, input logic [1:0] q, input logic b);
    unique case (k)
      ees_pkg::K_NONE: slot_lines = 2'h3;
      ees_pkg::K_BIT: slot_lines = {(q == 2'h1 || q == 2'h2), b};
      ees_pkg::K_START: slot_lines = {(q == 2'h1 || q == 2'h2), q < 2'h2};
      ees_pkg::K_STOP: slot_lines = {q != 2'h0, q >= 2'h2};
    endcase
  endfunction : slot_lines

  function automatic logic [7:0] dev_word(input logic sel, input logic [9:0] a, input logic rd);
    dev_word = {ees_pkg::TYPE_CODE, sel, a[9:8], rd};
  endfunction : dev_word

  always_comb begin
    h_d = h_q;
    h_d.sda_s1 = lnk.sda;
    h_d.sda_s2 = h_q.sda_s1;
    h_d.rvalid = 1'b0;
    h_d.wtake = 1'b0;
    h_d.done = 1'b0;
    h_d.nack = 1'b0;
    slot_end = 1'b0;
    if (h_q.st == ees_pkg::H_IDLE) begin
      h_d.q = '0;
      h_d.qc = '0;
      if (cmd_valid) begin
        h_d.addr = cmd_addr;
        h_d.rd = cmd_read;
        h_d.cnt = cmd_count;
        h_d.ph = ees_pkg::P_DEVW;
        h_d.st = ees_pkg::H_START;
      end
    end else begin
      if (h_q.qc == ees_pkg::QUARTER_LAST) begin
        h_d.qc = '0;
        h_d.q = h_q.q + 2'h1;
        slot_end = (h_q.q == ees_pkg::Q_LAST);
        if (h_q.q == ees_pkg::Q_SAMPLE) begin
          h_d.smp = h_q.sda_s2;
        end
      end else begin
        h_d.qc = h_q.qc + 4'h1;
      end
    end
    if (slot_end) begin
      unique case (h_q.st)
        ees_pkg::H_REC: begin
          h_d.rec = h_q.rec + 4'h1;
          if (h_q.rec == ees_pkg::RECOVER_LAST) begin
            h_d.st = ees_pkg::H_RSTART;
          end
        end
        ees_pkg::H_RSTART: h_d.st = ees_pkg::H_RSTOP;
        ees_pkg::H_RSTOP: h_d.st = ees_pkg::H_IDLE;
        ees_pkg::H_IDLE: h_d.st = ees_pkg::H_IDLE;
        ees_pkg::H_START: begin
          h_d.sh = dev_word(target_select, h_q.addr, h_q.ph == ees_pkg::P_DEVR);
          h_d.bitn = '0;
          h_d.st = ees_pkg::H_TX;
        end
        ees_pkg::H_TX: begin
          h_d.sh = {h_q.sh[6:0], 1'b1};
          h_d.bitn = h_q.bitn + 4'h1;
          if (h_q.bitn == ees_pkg::CNT_LAST) begin
            h_d.st = ees_pkg::H_TACK;
          end
        end
        ees_pkg::H_TACK: begin
          h_d.bitn = '0;
          h_d.st = ees_pkg::H_TX;
          if (h_q.smp) begin
            h_d.st = ees_pkg::H_STOP;
            if (h_q.ph != ees_pkg::P_POLL) begin
              h_d.ph = ees_pkg::P_ERR;
            end
          end else begin
            unique case (h_q.ph)
              ees_pkg::P_DEVW: begin
                h_d.sh = h_q.addr[7:0];
                h_d.ph = ees_pkg::P_ADDR;
              end
              ees_pkg::P_ADDR: begin
                if (h_q.rd) begin
                  h_d.ph = ees_pkg::P_DEVR;
                  h_d.st = ees_pkg::H_START;
                end else begin
                  h_d.sh = wr_data;
                  h_d.wtake = 1'b1;
                  h_d.ph = ees_pkg::P_DATA;
                end
              end
              ees_pkg::P_DATA: begin
                if (h_q.cnt == '0) begin
                  h_d.ph = ees_pkg::P_WDONE;
                  h_d.st = ees_pkg::H_STOP;
                end else begin
                  h_d.cnt = h_q.cnt - 4'h1;
                  h_d.sh = wr_data;
                  h_d.wtake = 1'b1;
                end
              end
              ees_pkg::P_DEVR: h_d.st = ees_pkg::H_RX;
              ees_pkg::P_POLL: begin
                h_d.ph = ees_pkg::P_END;
                h_d.st = ees_pkg::H_STOP;
              end
              ees_pkg::P_WDONE, ees_pkg::P_END, ees_pkg::P_ERR: h_d.st = ees_pkg::H_STOP;
            endcase
          end
        end
        ees_pkg::H_RX: begin
          h_d.rxb = {h_q.rxb[6:0], h_q.smp};
          h_d.bitn = h_q.bitn + 4'h1;
          if (h_q.bitn == ees_pkg::CNT_LAST) begin
            h_d.rdata = {h_q.rxb[6:0], h_q.smp};
            h_d.rvalid = 1'b1;
            h_d.st = ees_pkg::H_RACK;
          end
        end
        ees_pkg::H_RACK: begin
          h_d.bitn = '0;
          if (h_q.cnt == '0) begin
            h_d.ph = ees_pkg::P_END;
            h_d.st = ees_pkg::H_STOP;
          end else begin
            h_d.cnt = h_q.cnt - 4'h1;
            h_d.st = ees_pkg::H_RX;
          end
        end
        ees_pkg::H_STOP: begin
          h_d.st = ees_pkg::H_IDLE;
          if (h_q.ph == ees_pkg::P_WDONE || h_q.ph == ees_pkg::P_POLL) begin
            h_d.ph = ees_pkg::P_POLL;
            h_d.st = ees_pkg::H_START;
          end else if (h_q.ph == ees_pkg::P_ERR) begin
            h_d.nack = 1'b1;
          end else begin
            h_d.done = 1'b1;
          end
        end
      endcase
    end
    lines = slot_lines(slot_kind(h_d.st), h_d.q,
                       h_d.st == ees_pkg::H_TX ? h_d.sh[7] :
                       (h_d.st == ees_pkg::H_RACK ? (h_d.cnt == '0) : 1'b1));
    h_d.scl = lines[1];
    h_d.oe = !lines[0];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      h_q <= '{st: ees_pkg::H_REC, ph: ees_pkg::P_DEVW, scl: 1'b1, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  assign cmd_ready = (h_q.st == ees_pkg::H_IDLE);
  assign wr_take = h_q.wtake;
  assign rd_data = h_q.rdata;
  assign rd_valid = h_q.rvalid;
  assign done = h_q.done;
  assign nack_err = h_q.nack;
  assign lnk.scl = h_q.scl;
  assign lnk.sda_host_o = 1'b0;
  assign lnk.sda_host_oe = h_q.oe;

endmodule : ees_host

/* File: ees_link_asserts.sv */
// Wire-level checks of the two-wire memory link and the program timer
`timescale 1ns/10ps
module ees_link_asserts #(
  parameter int unsigned PROG_CYCLES = ees_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda,
  input wire logic standby,
  input wire logic program_busy
);
  logic scl_q;
  logic sda_q;
  logic [3:0] rises_q;
  logic [17:0] busy_cnt_q;
  logic start_w;
  logic stop_w;

  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;

  // Counts serial clock rises since the last start, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rises_q <= 4'h0;
      busy_cnt_q <= 18'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_w) begin
        rises_q <= 4'h0;
      end else if (scl && !scl_q && rises_q != 4'hf) begin
        rises_q <= rises_q + 4'h1;
      end
      busy_cnt_q <= program_busy ? busy_cnt_q + 18'h1 : 18'h0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  dev_oe_edge_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device data output changed while clock high");
  drain_low_a: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
    else $error("device drive does not pull the wire low");
  addr_no_drive_a: assert property (rises_q < 4'h8 |-> !sda_dev_oe)
    else $error("device drives during the address bits");
  busy_no_ack_a: assert property (program_busy |-> !sda_dev_oe)
    else $error("device answers during program cycle");
  busy_length_a: assert property ($fell(program_busy) |-> busy_cnt_q == 18'(PROG_CYCLES))
    else $error("program cycle length wrong");
  busy_bound_a: assert property (program_busy |-> busy_cnt_q < 18'(PROG_CYCLES))
    else $error("program cycle overruns");
  standby_busy_a: assert property (program_busy |-> !standby)
    else $error("standby during program cycle");
  stop_idle_a: assert property (stop_w |=> scl [*8])
    else $error("clock moves right after stop");
  start_clock_a: assert property (start_w |-> ##[1:40] !scl)
    else $error("no clock after start");
  host_hold_a: assert property ($fell(scl) |-> $stable(sda_host_oe))
    else $error("controller data moved on the clock falling edge");
  host_drain_a: assert property (sda_host_oe |-> !sda_host_o && !sda)
    else $error("controller drive does not pull the wire low");

  start_seen_c: cover property (start_w);
  ack_seen_c: cover property (rises_q == 4'h8 && sda_dev_oe);
  program_seen_c: cover property ($rose(program_busy));
endmodule : ees_link_asserts

/* File: two_wire_serial_eeprom_slave_bench.sv */
// Self-checking bench joining the memory device and its bus controller
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module two_wire_serial_eeprom_slave_bench;
  localparam int unsigned PROG = 200;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic write_protect = 1'b0;
  logic hsel = 1'b0;
  logic target_select = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [9:0] cmd_addr = 10'h000;
  logic [3:0] cmd_count = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_take, rd_valid, done, nack_err, standby, program_busy;
  logic [7:0] rd_data;
  logic busy_q = 1'b0;
  int n_fail = 0;
  int checks = 0;
  int seed = 32'h852f_f158;
  int widx = 0;
  int nbusy = 0;
  logic [7:0] wq[16];
  logic [7:0] rq[$];
  logic [7:0] mem[1024];

  ees_link_if lnk_if();
  ees_device #(.PROG_CYCLES(PROG)) ees_device_inst (.clock(clock), .rst_b(rst_b), .write_protect(write_protect),
    .hardwired_select_input(hsel), .standby(standby), .program_busy(program_busy), .lnk(lnk_if));
  ees_host ees_host_inst (.clock(clock), .rst_b(rst_b), .target_select(target_select), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_count(cmd_count), .wr_data(wr_data),
    .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_err(nack_err), .lnk(lnk_if));
  ees_link_asserts #(.PROG_CYCLES(PROG)) ees_link_asserts_inst (.clock(clock), .rst_b(rst_b), .scl(lnk_if.scl),
    .sda_host_o(lnk_if.sda_host_o), .sda_host_oe(lnk_if.sda_host_oe), .sda_dev_o(lnk_if.sda_dev_o),
    .sda_dev_oe(lnk_if.sda_dev_oe), .sda(lnk_if.sda), .standby(standby), .program_busy(program_busy));

  always #10 clock = ~clock;

  // Feeds write bytes, collects read bytes, counts program cycles
  always @(posedge clock) begin
    if (wr_take === 1'b1) begin
      widx <= widx + 1;
      wr_data <= wq[4'(widx + 1)];
    end
    if (rd_valid === 1'b1) begin
      rq.push_back(rd_data);
    end
    busy_q <= program_busy;
    if (program_busy === 1'b1 && busy_q === 1'b0) begin
      nbusy <= nbusy + 1;
    end
  end

  task automatic complete_run();
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic run_cmd(input logic rd, input logic [9:0] a, input logic [3:0] c, input logic sel,
                         output logic ok);
    @(posedge clock);
    widx = 0;
    rq.delete();
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_count <= c;
    target_select <= sel;
    wr_data <= wq[0];
    do @(negedge clock); while (cmd_ready !== 1'b1);
    @(posedge clock);
    cmd_valid <= 1'b0;
    do @(negedge clock); while (done !== 1'b1 && nack_err !== 1'b1);
    ok = done;
    @(posedge clock);
  endtask : run_cmd

  task automatic wr(input logic [9:0] a, input logic [3:0] c);
    logic ok;
    int nb;
    nb = nbusy;
    for (int i = 0; i < 16; i++) wq[i] = 8'($random(seed));
    run_cmd(1'b0, a, c, hsel, ok);
    `CHK(ok, 1'b1)
    `CHK(nbusy - nb, (write_protect === 1'b1) ? 0 : 1)
    if (write_protect !== 1'b1) begin
      for (int i = 0; i <= c; i++) mem[{a[9:4], 4'(a[3:0] + i)}] = wq[i];
    end
  endtask : wr

  task automatic rdc(input logic [9:0] a, input logic [3:0] c);
    logic ok;
    run_cmd(1'b1, a, c, hsel, ok);
    `CHK(ok, 1'b1)
    `CHK(rq.size(), c + 1)
    for (int i = 0; i <= c; i++) `CHK(rq[i], mem[10'(a + i)])
  endtask : rdc

  initial begin
    logic ok;
    logic [9:0] a;
    logic [3:0] c;
    repeat (8) @(posedge clock);
    hsel <= 1'($random(seed));
    rst_b <= 1'b1;
    @(negedge clock);
    `CHK(standby, 1'b1)
    wr(10'h000, 4'hf);
    rdc(10'h000, 4'hf);
    wr(10'h00e, 4'h3);
    rdc(10'h000, 4'hf);
    wr(10'h3ff, 4'h0);
    rdc(10'h3ff, 4'h1);
    @(posedge clock);
    write_protect <= 1'b1;
    wr(10'h005, 4'h2);
    write_protect <= 1'b0;
    rdc(10'h000, 4'hf);
    for (int r = 0; r < 2; r++) begin
      run_cmd(1'(r), 10'h010, 4'h0, ~hsel, ok);
      `CHK(ok, 1'b0)
    end
    repeat (3) begin
      a = 10'($random(seed));
      c = 4'($unsigned($random(seed)) % (16 - a[3:0]));
      wr(a, c);
      rdc(a, c);
    end
    repeat (10) @(negedge clock);
    `CHK(standby, 1'b1)
    complete_run();
  end

  // Cuts a hang short
  initial begin
    repeat (120000) @(posedge clock);
    n_fail++;
    complete_run();
  end
endmodule : two_wire_serial_eeprom_slave_bench
